// >>> prot_status_cfg.svh
`ifndef PROT_STATUS_CFG_SVH
`define PROT_STATUS_CFG_SVH

// register offsets on the command port
`define ADR_STATUS 8'h00
`define ADR_ALERT_A 8'h02
`define ADR_FAULT_A 8'h03
`define ADR_ALERT_T 8'h04
`define ADR_FAULT_T 8'h05
`define ADR_INT_STATUS 8'h06
`define ADR_INT_MASK 8'h07
`define ADR_EN_A 8'h08
`define ADR_EN_T 8'h09
`define ADR_SUB_LO 8'h3e
`define ADR_SUB_HI 8'h3f

// field positions
`define BIT_DEEP 2
`define BIT_LOAD_PROBE_TIMED_OUT 1
`define BIT_LD_PULLUP 0
`define BIT_T_RSVD 3
`define INT_FAULT_A 0
`define INT_FAULT_T 1
`define INT_ALERT 2
`define INT_LOAD_PROBE_TIMED_OUT 3

// values and reset values
`define STATUS_SIGNATURE 16'hffa5
`define MASK_GROUP_A 8'hfc
`define MASK_THERMAL 8'hf7
`define RST_ENABLE 8'hff
`define RST_INT_MASK 4'h0

`endif

// >>> prot_status_pkg.sv
package prot_status_pkg;

  // live device state bits
  typedef struct packed {
    logic lowest_power_state_flag;
    logic load_probe_timed_out;
    logic load_probe_pullup_active;
  } dev_state_s;

  // current and voltage protection sources, bit 7 down to bit 0
  typedef struct packed {
    logic discharge_short_circuit;
    logic discharge_overcurrent_tier_two;
    logic discharge_overcurrent_tier_one;
    logic charge_overcurrent;
    logic cell_overvoltage;
    logic cell_undervoltage;
    logic [1:0] spare;
  } prot_a_s;

  // temperature protection sources, bit 7 down to bit 0
  typedef struct packed {
    logic switch_overtemp;
    logic die_overtemp;
    logic discharge_overtemp;
    logic charge_overtemp;
    logic spare;
    logic die_undertemp;
    logic discharge_undertemp;
    logic charge_undertemp;
  } thermal_s;

  // state of one flag byte
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] rise;
  } flag_st_s;

  // state of the register bank
  typedef struct packed {
    logic [15:0] rdata;
    logic sig_pend;
    logic sub_vld;
    logic [15:0] sub_data;
    logic [7:0] en_a;
    logic [7:0] en_t;
    logic [3:0] int_st;
    logic [3:0] int_mask;
    logic irq;
    logic ld_to_q;
  } bank_st_s;

endpackage

// >>> flag_byte_reg.sv
`timescale 1ns/1ps
`include "prot_status_cfg.svh"

module flag_byte_reg #(
  parameter logic [7:0] VALID_MASK = 8'hff
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [7:0] i_raw,
  input wire logic [7:0] i_enable,
  output prot_status_pkg::flag_st_s o_st
);
  import prot_status_pkg::*;

  flag_st_s q;
  flag_st_s nxt;

  // only enabled, defined sources reach the byte; rise marks new bits
  always_comb begin
    nxt = q;
    nxt.flags = i_raw & i_enable & VALID_MASK;
    nxt.rise = nxt.flags & ~q.flags;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else if (i_ce) begin
      q <= nxt;
    end
  end

  assign o_st = q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  a_flags_gated_enable: assert property ($past(i_ce) |-> q.flags == ($past(i_raw & i_enable) & VALID_MASK))
    else $error("flag byte not raw gated by enable");
  a_rise_new_bits: assert property ($past(i_ce) |-> q.rise == (q.flags & ~$past(q.flags)))
    else $error("rise pulse does not match newly set flags");
endmodule

// >>> protection_status_registers.sv
`timescale 1ns/1ps
`include "prot_status_cfg.svh"

module protection_status_registers (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire prot_status_pkg::dev_state_s i_dev_state,
  input wire prot_status_pkg::prot_a_s i_alert_a_raw,
  input wire prot_status_pkg::prot_a_s i_fault_a_raw,
  input wire prot_status_pkg::thermal_s i_alert_t_raw,
  input wire prot_status_pkg::thermal_s i_fault_t_raw,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_subcmd_valid,
  output logic [15:0] o_subcmd_data
);
  import prot_status_pkg::*;

  bank_st_s q;
  bank_st_s nxt;
  flag_st_s alert_a;
  flag_st_s fault_a;
  flag_st_s alert_t;
  flag_st_s fault_t;
  logic [3:0] events;
  logic rd_int;

  // widen a flag byte onto the read word, upper byte zero
  function automatic logic [15:0] byte_word(input logic [7:0] b);
    byte_word = {8'h00, b};
  endfunction

  // flag bytes for current and voltage protections
  flag_byte_reg #(
    .VALID_MASK(`MASK_GROUP_A)
  ) u_alert_a (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_raw(i_alert_a_raw),
    .i_enable(q.en_a),
    .o_st(alert_a)
  );

  flag_byte_reg #(
    .VALID_MASK(`MASK_GROUP_A)
  ) u_fault_a (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_raw(i_fault_a_raw),
    .i_enable(q.en_a),
    .o_st(fault_a)
  );

  // flag bytes for temperature protections
  flag_byte_reg #(
    .VALID_MASK(`MASK_THERMAL)
  ) u_alert_t (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_raw(i_alert_t_raw),
    .i_enable(q.en_t),
    .o_st(alert_t)
  );

  flag_byte_reg #(
    .VALID_MASK(`MASK_THERMAL)
  ) u_fault_t (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_raw(i_fault_t_raw),
    .i_enable(q.en_t),
    .o_st(fault_t)
  );

  // interrupt events: new faults, new alerts, load probe timeout edge
  always_comb begin
    events = 4'h0;
    events[`INT_FAULT_A] = |fault_a.rise;
    events[`INT_FAULT_T] = |fault_t.rise;
    events[`INT_ALERT] = (|alert_a.rise) | (|alert_t.rise);
    events[`INT_LOAD_PROBE_TIMED_OUT] = i_dev_state.load_probe_timed_out & ~q.ld_to_q;
  end

  assign rd_int = i_rd && (i_addr == `ADR_INT_STATUS);

  // register writes, read mux and interrupt bookkeeping
  always_comb begin
    nxt = q;
    nxt.sub_vld = 1'b0;
    nxt.rdata = 16'h0000;
    nxt.ld_to_q = i_dev_state.load_probe_timed_out;
    if (i_wr) begin
      case (i_addr)
        `ADR_STATUS: begin
          nxt.sig_pend = 1'b1;
          nxt.sub_vld = 1'b1;
          nxt.sub_data = i_wdata;
        end
        `ADR_SUB_LO: begin
          nxt.sub_vld = 1'b1;
          nxt.sub_data = i_wdata;
        end
        `ADR_SUB_HI: begin
          nxt.sub_vld = 1'b1;
          nxt.sub_data = {i_wdata[7:0], q.sub_data[7:0]};
        end
        `ADR_INT_MASK: begin
          nxt.int_mask = i_wdata[3:0];
        end
        `ADR_EN_A: begin
          nxt.en_a = i_wdata[7:0];
        end
        `ADR_EN_T: begin
          nxt.en_t = i_wdata[7:0];
        end
        default: begin
          // alert and fault bytes only report status
          nxt.sub_vld = 1'b0;
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `ADR_STATUS: begin
          if (q.sig_pend) begin
            nxt.rdata = `STATUS_SIGNATURE;
            nxt.sig_pend = 1'b0;
          end else begin
            nxt.rdata[`BIT_DEEP] = i_dev_state.lowest_power_state_flag;
            nxt.rdata[`BIT_LOAD_PROBE_TIMED_OUT] = i_dev_state.load_probe_timed_out;
            nxt.rdata[`BIT_LD_PULLUP] = i_dev_state.load_probe_pullup_active;
          end
        end
        `ADR_ALERT_A: begin
          nxt.rdata = byte_word(alert_a.flags);
        end
        `ADR_FAULT_A: begin
          nxt.rdata = byte_word(fault_a.flags);
        end
        `ADR_ALERT_T: begin
          nxt.rdata = byte_word(alert_t.flags);
        end
        `ADR_FAULT_T: begin
          nxt.rdata = byte_word(fault_t.flags);
        end
        `ADR_INT_STATUS: begin
          nxt.rdata = {12'h000, q.int_st};
        end
        `ADR_INT_MASK: begin
          nxt.rdata = {12'h000, q.int_mask};
        end
        `ADR_EN_A: begin
          nxt.rdata = byte_word(q.en_a);
        end
        `ADR_EN_T: begin
          nxt.rdata = byte_word(q.en_t);
        end
        default: begin
          // unmapped addresses read zero
          nxt.rdata = 16'h0000;
        end
      endcase
    end
    // an interrupt status read clears the sticky bits, a new event in that cycle still sets
    nxt.int_st = (rd_int ? 4'h0 : q.int_st) | events;
    nxt.irq = |(nxt.int_st & nxt.int_mask);
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.en_a <= `RST_ENABLE;
      q.en_t <= `RST_ENABLE;
      q.int_mask <= `RST_INT_MASK;
    end else if (i_ce) begin
      q <= nxt;
    end
  end

  // outputs straight from the state register
  assign o_rdata = q.rdata;
  assign o_irq = q.irq;
  assign o_subcmd_valid = q.sub_vld;
  assign o_subcmd_data = q.sub_data;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // word write to the status register
  sequence s_word_write;
    i_ce && i_wr && (i_addr == `ADR_STATUS);
  endsequence

  // read of the status register
  sequence s_status_read;
    i_ce && i_rd && (i_addr == `ADR_STATUS);
  endsequence

  a_sig_first_read: assert property (s_word_write ##1 s_status_read |=> o_rdata == `STATUS_SIGNATURE)
    else $error("signature not returned after status write");

  a_sig_only_once: assert property (s_word_write ##1 s_status_read ##1 s_status_read |=> o_rdata[15:3] == 13'h0000)
    else $error("signature returned more than once");

  a_sub_mirror: assert property (s_word_write |=> o_subcmd_valid && o_subcmd_data == $past(i_wdata))
    else $error("status write not passed as subcommand");

  // status word bits follow the live device state
  a_deep_bit_live: assert property ((s_status_read and !q.sig_pend)
    |=> o_rdata[`BIT_DEEP] == $past(i_dev_state.lowest_power_state_flag))
    else $error("lowest power flag wrong on read");

  a_load_probe_timed_out_bit: assert property ((s_status_read and !q.sig_pend)
    |=> o_rdata[`BIT_LOAD_PROBE_TIMED_OUT] == $past(i_dev_state.load_probe_timed_out))
    else $error("load probe timeout flag wrong on read");

  a_ld_pullup_bit: assert property ((s_status_read and !q.sig_pend)
    |=> o_rdata[`BIT_LD_PULLUP] == $past(i_dev_state.load_probe_pullup_active))
    else $error("load probe pullup flag wrong on read");

  // live status reads keep the reserved upper bits clear
  a_status_rsvd_zero: assert property ((s_status_read and !q.sig_pend) |=> o_rdata[15:3] == 13'h0000)
    else $error("reserved status bit set on read");

  // read of a flag byte whose contents were stored with the clock enabled
  sequence s_byte_read(logic [7:0] adr);
    $past(i_ce) && i_ce && i_rd && (i_addr == adr);
  endsequence

  // flag bytes follow raw sources gated by their enables
  a_alert_a_read: assert property (s_byte_read(`ADR_ALERT_A)
    |=> o_rdata == byte_word($past(i_alert_a_raw & q.en_a, 2) & `MASK_GROUP_A))
    else $error("alert byte a does not follow enabled sources");

  a_fault_a_read: assert property (s_byte_read(`ADR_FAULT_A)
    |=> o_rdata == byte_word($past(i_fault_a_raw & q.en_a, 2) & `MASK_GROUP_A))
    else $error("fault byte a does not follow enabled sources");

  a_disabled_stays_clear: assert property (s_byte_read(`ADR_ALERT_T)
    |=> (o_rdata[7:0] & ~$past(q.en_t, 2)) == 8'h00)
    else $error("flag set for a disabled protection");

  a_thermal_alert_read: assert property (s_byte_read(`ADR_ALERT_T)
    |=> o_rdata == byte_word($past(i_alert_t_raw & q.en_t, 2) & `MASK_THERMAL))
    else $error("thermal alert byte does not follow enabled sources");

  a_thermal_fault_read: assert property (s_byte_read(`ADR_FAULT_T)
    |=> o_rdata == byte_word($past(i_fault_t_raw & q.en_t, 2) & `MASK_THERMAL))
    else $error("thermal fault byte does not follow enabled sources");

  // thermal fault byte keeps its reserved bit clear
  a_thermal_fault_rsvd: assert property (i_ce && i_rd && i_addr == `ADR_FAULT_T
    |=> o_rdata[`BIT_T_RSVD] == 1'b0 && o_rdata[15:8] == 8'h00)
    else $error("reserved bit of thermal fault byte set");

  // addresses above the enable registers read zero
  a_unmapped_zero: assert property (i_ce && i_rd && i_addr > `ADR_EN_T
    |=> o_rdata == 16'h0000)
    else $error("unmapped address returned data");

  // writes to the flag bytes and the event register
  sequence s_flag_write;
    i_ce && i_wr && (i_addr >= `ADR_ALERT_A) && (i_addr <= `ADR_INT_STATUS);
  endsequence

  a_flag_write_ignored: assert property (s_flag_write |=> !o_subcmd_valid && $stable(o_subcmd_data)
    && $stable(q.en_a) && $stable(q.en_t) && $stable(q.int_mask))
    else $error("write to a status byte changed the bank");

  // subcommand writes
  a_sub_lo_word: assert property (i_ce && i_wr && i_addr == `ADR_SUB_LO
    |=> o_subcmd_valid && o_subcmd_data == $past(i_wdata))
    else $error("low subcommand write not passed on");

  a_sub_hi_byte: assert property (i_ce && i_wr && i_addr == `ADR_SUB_HI
    |=> o_subcmd_valid && o_subcmd_data == {$past(i_wdata[7:0]), $past(o_subcmd_data[7:0])})
    else $error("high subcommand byte not merged");

  // the subcommand strobe lasts one cycle
  a_sub_pulse_once: assert property (i_ce && !i_wr |=> !o_subcmd_valid)
    else $error("subcommand strobe held too long");

  // read data stand only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
    else $error("read data left standing");

  // a low clock enable freezes every output
  a_ce_freeze: assert property (!i_ce |=> $stable(o_rdata) && $stable(o_irq) && $stable(o_subcmd_valid)
    && $stable(o_subcmd_data))
    else $error("state moved while the clock enable was low");

  // a newly enabled source reaches its flag byte, then its event bit
  sequence s_new_fault_a;
    i_ce && ((i_fault_a_raw & q.en_a & `MASK_GROUP_A & ~fault_a.flags) != 8'h00) ##1 i_ce;
  endsequence

  sequence s_new_fault_t;
    i_ce && ((i_fault_t_raw & q.en_t & `MASK_THERMAL & ~fault_t.flags) != 8'h00) ##1 i_ce;
  endsequence

  sequence s_new_alert_a;
    i_ce && ((i_alert_a_raw & q.en_a & `MASK_GROUP_A & ~alert_a.flags) != 8'h00) ##1 i_ce;
  endsequence

  a_fault_a_event: assert property (s_new_fault_a |=> q.int_st[`INT_FAULT_A])
    else $error("new fault in group a did not set its event");

  a_fault_t_event: assert property (s_new_fault_t |=> q.int_st[`INT_FAULT_T])
    else $error("new thermal fault did not set its event");

  a_alert_event: assert property (s_new_alert_a |=> q.int_st[`INT_ALERT])
    else $error("new alert did not set its event");

  // a rising load probe timeout sets its event bit
  a_load_probe_timed_out_event: assert property (i_ce && i_dev_state.load_probe_timed_out && !q.ld_to_q
    |=> q.int_st[`INT_LOAD_PROBE_TIMED_OUT])
    else $error("load probe timeout did not set its event");

  // an unmasked pending event holds the line high unless the status is read or the mask changes
  a_irq_follows_status: assert property (i_ce && !rd_int && !(i_wr && i_addr == `ADR_INT_MASK)
    && (|(q.int_st & q.int_mask)) |=> o_irq)
    else $error("interrupt not raised for a pending unmasked event");

  // a status read with no new event in that cycle drops the line
  a_irq_read_clears: assert property (i_ce && rd_int && events == 4'h0 |=> !o_irq)
    else $error("interrupt not cleared by status read");
endmodule

// >>> host_model.sv
`timescale 1ns/1ps

module host_model (
  input wire logic i_mclk,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // expected read data, oldest first, as {address, data}
  logic [23:0] exp_q[$];

  // bus idles with both strobes low
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // one-cycle write; the status word is written only by the legacy detection test
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d;  // data is not held past the strobe
  endtask

  // word write followed at once by two reads of the same address
  task automatic wr_rdrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e1,
    input logic [15:0] e2);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    o_rd <= 1'b1;
    exp_q.push_back({a, e1});
    @(posedge i_mclk);
    exp_q.push_back({a, e2});
    @(posedge i_mclk);
    o_rd <= 1'b0;
  endtask

  // one-cycle read; the expected answer is noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge i_mclk);
    o_rd <= 1'b0;
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "prot_status_cfg.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  import prot_status_pkg::*;
  logic mclk, rst_b, ce, wr, rd, irq, sub_vld;
  logic pend = 1'b0;
  logic [7:0] addr, ea, et;
  logic [15:0] wdata, rdata, sub_data, w, w2;
  logic [23:0] ent;
  dev_state_s dev_state;
  prot_a_s alert_a, fault_a;
  thermal_s alert_t, fault_t;
  int err_total = 0;
  int checks_done = 0;

  protection_status_registers i_protection_status_registers (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_dev_state(dev_state), .i_alert_a_raw(alert_a),
    .i_fault_a_raw(fault_a), .i_alert_t_raw(alert_t), .i_fault_t_raw(fault_t), .o_rdata(rdata), .o_irq(irq),
    .o_subcmd_valid(sub_vld), .o_subcmd_data(sub_data));
  host_model i_host_model (.i_mclk(mclk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // read data stands in the cycle after the strobe; compare with the oldest note
  always @(posedge mclk) begin
    if (pend) begin
      if (i_host_model.exp_q.size() == 0) begin
        err_total++;
        $display("[FAIL] rdata expected none seen %h", rdata);
      end else begin
        ent = i_host_model.exp_q.pop_front();
        `CHK("rdata", ent[15:0], rdata)
      end
    end
    pend = rd & rst_b;
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    results();
  end

  // main sequence
  initial begin
    void'($urandom(32'he3d0768b));
    {rst_b, ce, dev_state, alert_a, fault_a, alert_t, fault_t} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    ce <= 1'b1;
    i_host_model.rd(`ADR_EN_A, 16'h00ff);
    i_host_model.rd(`ADR_EN_T, 16'h00ff);
    i_host_model.rd(`ADR_INT_MASK, 16'h0000);
    // unmasked fault raises the interrupt, a status read clears it
    i_host_model.wr(`ADR_INT_MASK, 16'h0001);
    fault_a <= prot_a_s'(8'h80);
    repeat (4) @(posedge mclk);
    #1 `CHK("irq", 1'b1, irq)
    i_host_model.rd(`ADR_INT_STATUS, 16'h0001);
    repeat (3) @(posedge mclk);
    #1 `CHK("irq", 1'b0, irq)
    // masked alert event does not raise the line
    alert_a <= prot_a_s'(8'h04);
    repeat (4) @(posedge mclk);
    #1 `CHK("irq", 1'b0, irq)
    i_host_model.rd(`ADR_INT_STATUS, 16'h0004);
    // disabled protection never flags
    i_host_model.wr(`ADR_EN_A, 16'h0000);
    fault_a <= prot_a_s'(8'hc0);
    repeat (4) @(posedge mclk);
    i_host_model.rd(`ADR_INT_STATUS, 16'h0000);
    i_host_model.rd(`ADR_FAULT_A, 16'h0000);
    // live status bits, every combination
    for (int v = 0; v < 8; v++) begin
      dev_state <= dev_state_s'(v[2:0]);
      i_host_model.rd(`ADR_STATUS, 16'(v));
    end
    i_host_model.rd(`ADR_INT_STATUS, 16'h0008);
    // word write to the status word, then signature once
    w = 16'($urandom);
    i_host_model.wr(`ADR_STATUS, w);
    #1 `CHK("subcmd_valid", 1'b1, sub_vld)
    `CHK("subcmd_data", w, sub_data)
    i_host_model.rd(`ADR_FAULT_A, 16'h0000);
    i_host_model.rd(`ADR_STATUS, `STATUS_SIGNATURE);
    i_host_model.rd(`ADR_STATUS, {13'h0000, dev_state});
    i_host_model.wr_rdrd(`ADR_STATUS, w, `STATUS_SIGNATURE, {13'h0000, dev_state});
    w2 = 16'($urandom);
    i_host_model.wr(`ADR_SUB_LO, w2);
    #1 `CHK("subcmd_data", w2, sub_data)
    i_host_model.wr(`ADR_SUB_HI, w);
    #1 `CHK("subcmd_data", {w[7:0], w2[7:0]}, sub_data)
    @(posedge mclk);
    #1 `CHK("subcmd_valid", 1'b0, sub_vld)
    // clock enable low for a few cycles freezes the bank
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    // random sources and enables against the four flag bytes
    repeat (8) begin
      ea = 8'($urandom);
      et = 8'($urandom);
      i_host_model.wr(`ADR_EN_A, {8'h00, ea});
      i_host_model.wr(`ADR_EN_T, {8'h00, et});
      alert_a <= prot_a_s'(8'($urandom));
      fault_a <= prot_a_s'(8'($urandom));
      alert_t <= thermal_s'(8'($urandom));
      fault_t <= thermal_s'(8'($urandom));
      repeat (2) @(posedge mclk);
      i_host_model.wr(`ADR_ALERT_A, 16'hffff);
      i_host_model.wr(`ADR_FAULT_T, 16'hffff);
      i_host_model.rd(`ADR_EN_A, {8'h00, ea});
      i_host_model.rd(`ADR_ALERT_A, {8'h00, alert_a & ea & `MASK_GROUP_A});
      i_host_model.rd(`ADR_FAULT_A, {8'h00, fault_a & ea & `MASK_GROUP_A});
      i_host_model.rd(`ADR_ALERT_T, {8'h00, alert_t & et & `MASK_THERMAL});
      i_host_model.rd(`ADR_FAULT_T, {8'h00, fault_t & et & `MASK_THERMAL});
      i_host_model.rd(8'h20, 16'h0000);
    end
    repeat (3) @(posedge mclk);
    `CHK("pending reads", 0, i_host_model.exp_q.size())
    results();
  end
endmodule
